// ---- bmm_pkg.sv ----
// Purpose: shared constants and types for the bus memory module
// Assumes: 16-bit data, 16-bit word address on the shared system bus
// Notes:   all timing counts derive from the 40 MHz core clock
package bmm_pkg;

  // core clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS   = 25000;
  // normal and extended bus cycle lengths in nanoseconds
  localparam int unsigned NORM_CYCLE_NS   = 1050;
  localparam int unsigned EXT_CYCLE_NS    = 1750;
  // extra time an extended cycle adds, longest time so rounded down
  localparam int unsigned EXT_EXTRA_CYC   =
    ((EXT_CYCLE_NS - NORM_CYCLE_NS) * 1000) / CLK_PERIOD_PS;

  // word and address widths
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned ADDR_W          = 16;
  // read/write store depth and its index width
  localparam int unsigned RAM_WORDS       = 4096;
  localparam int unsigned RAM_AW          = 12;
  // read-only store depth and its index width
  localparam int unsigned ROM_WORDS       = 512;
  localparam int unsigned ROM_AW          = 9;
  // width of the strapped window select
  localparam int unsigned BASE_W          = ADDR_W - RAM_AW;
  // fixed read-only window
  localparam logic [15:0] ROM_FIRST       = 16'hFF00;
  localparam logic [15:0] ROM_LAST        = 16'hFFFF;
  // reset value of the data bus output
  localparam logic [15:0] DATA_RST        = 16'h0000;

  // transaction qualifiers sampled from the control bus
  typedef struct packed {
    logic mem;   // memory (not peripheral) transaction
    logic rd;    // read request
    logic wr;    // write request
  } bmm_ctl_t;

  // drive set for the shared data lines
  typedef struct packed {
    logic [15:0] data;
    logic        oe;
  } bmm_drv_t;

endpackage

// ---- bmm_top.sv ----
// Purpose: memory slave on the shared asynchronous system bus
// Assumes: strobes, address and data come from outside; all are
//          synchronised before use; base straps are static wiring
// Notes:   optional read-only store sits at the top of the map
//
// Overview of operation
// - 4096 word 16 bit read/write store
// - optional 512 word read-only routine store
// - answer only memory transactions in window
// - strapped window base, 4096 word steps
// - store access fits one normal cycle
// - read-only access uses an extended cycle
// - read-only store fixed FF00-FFFF, writes ignored
// - slave drives data lines only for reads
// - sample or drive only inside strobes
`timescale 1ns/100ps

module bmm_top #(
  parameter bit ROM_EN = 1'b1                  // read-only store fitted
) (
  input  wire logic        core_clk,           // 40 MHz clock
  input  wire logic        rst_n,              // async reset, active low
  input  wire logic        clk_en,             // freezes all state except the reset release chain when low
  input  wire logic [3:0]  base_sel,           // strapped window select
  input  wire logic        addr_stb,           // address strobe from master
  input  wire logic        data_stb,           // data strobe from master
  input  wire logic        bus_mem,            // memory transaction flag
  input  wire logic        bus_rd,             // read transaction
  input  wire logic        bus_wr,             // write transaction
  input  wire logic [15:0] bus_addr,           // address lines
  input  wire logic [15:0] data_in,            // data lines as seen
  output logic      [15:0] data_out,           // data lines driven
  output logic             data_oe,            // high while driving data
  output logic             ext_cycle,          // extended-cycle line
  output logic             ext_cycle_oe        // high while driving it
);

  // elaboration check: decode and stretch counter serve only this geometry
  if (bmm_pkg::BASE_W != 4 || bmm_pkg::EXT_EXTRA_CYC < 1) begin
    $error("bmm_top: unsupported geometry");
  end

  ////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic [1:0]  rst_sync;                       // reset release chain
  logic        rst_l;                          // released reset copy
  logic [2:0]  s_astb, s_dstb;                 // strobe chains
  logic [2:0]  s_mem, s_rd, s_wr;              // control chains
  logic [15:0] s_addr [3];                     // address chain
  logic [15:0] s_data [3];                     // data chain
  logic        astb, dstb;                     // filtered strobes
  bmm_pkg::bmm_ctl_t ctl;                      // filtered control
  logic [15:0] addr, wdata;                    // filtered words

  // two-flop release of the asynchronous reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_l = rst_sync[1];

  // three-flop chains; the first flop feeds only the second
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      s_astb <= 3'h0;
      s_dstb <= 3'h0;
      s_mem  <= 3'h0;
      s_rd   <= 3'h0;
      s_wr   <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        s_addr[i] <= 16'h0000;
        s_data[i] <= 16'h0000;
      end
    end else if (clk_en) begin
      s_astb <= {s_astb[1:0], addr_stb};
      s_dstb <= {s_dstb[1:0], data_stb};
      s_mem  <= {s_mem[1:0], bus_mem};
      s_rd   <= {s_rd[1:0], bus_rd};
      s_wr   <= {s_wr[1:0], bus_wr};
      s_addr[0] <= bus_addr;
      s_data[0] <= data_in;
      for (int i = 1; i < 3; i++) begin
        s_addr[i] <= s_addr[i-1];
        s_data[i] <= s_data[i-1];
      end
    end
  end

  // a level counts once the second and third stages agree
  logic astb_q, dstb_q;                        // accepted strobe levels
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      astb_q <= 1'b0;
      dstb_q <= 1'b0;
    end else if (clk_en) begin
      if (s_astb[1] == s_astb[2]) astb_q <= s_astb[2];
      if (s_dstb[1] == s_dstb[2]) dstb_q <= s_dstb[2];
    end
  end
  assign astb  = astb_q;
  assign dstb  = dstb_q;
  // qualifiers and words are stable under the strobes, take stage three
  assign ctl   = '{mem: s_mem[2], rd: s_rd[2], wr: s_wr[2]};
  assign addr  = s_addr[2];
  assign wdata = s_data[2];

  ////////////////////////////////////////////////////////////////////////
  // address decode

  // true when the word address falls in the strapped read/write window
  function automatic logic in_ram(input logic [15:0] a,
                                  input logic [3:0]  b);
    in_ram = (a[15:12] == b);
  endfunction

  // true when the word address falls in the fixed read-only window
  function automatic logic in_rom(input logic [15:0] a);
    in_rom = (a >= bmm_pkg::ROM_FIRST) && (a <= bmm_pkg::ROM_LAST);
  endfunction

  logic [3:0] base;                            // straps caught after reset
  logic       base_ok;                         // straps captured
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      base    <= 4'h0;
      base_ok <= 1'b0;
    end else if (clk_en && !base_ok) begin
      base    <= base_sel;
      base_ok <= 1'b1;
    end
  end

  logic hit_rom, hit_ram;                      // decoded targets
  // read-only window wins over an overlapping read/write window
  assign hit_rom = ROM_EN && ctl.mem && in_rom(addr);
  assign hit_ram = base_ok && ctl.mem && !hit_rom
                   && in_ram(addr, base);

  ////////////////////////////////////////////////////////////////////////
  // storage

  logic [15:0] ram [bmm_pkg::RAM_WORDS];       // read/write store
  logic [15:0] rom [bmm_pkg::ROM_WORDS];       // routine store, tied init

  // routine contents: plain constant table, zero until firmware fitted
  always_comb begin
    for (int i = 0; i < bmm_pkg::ROM_WORDS; i++) begin
      rom[i] = bmm_pkg::DATA_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transaction state machine

  typedef enum logic [3:0] {
    BMM_IDLE = 4'h1,                           // waiting for a strobe
    BMM_RAM  = 4'h2,                           // read/write store access
    BMM_ROM  = 4'h4,                           // stretched read-only access
    BMM_DONE = 4'h8                            // wait for strobe release
  } bmm_state_t;

  bmm_state_t  st, next_st;                    // state
  logic [7:0]  cnt, next_cnt;                  // stretch counter
  bmm_pkg::bmm_drv_t drv, next_drv;            // data line drive
  logic        ext, next_ext;                  // extended-cycle drive
  logic        we;                             // store write this cycle
  logic [11:0] widx;                           // store write index

  // next-state logic for one bus cycle
  always_comb begin
    next_st  = st;
    next_cnt = cnt;
    next_drv = drv;
    next_ext = ext;
    we       = 1'b0;
    widx     = addr[bmm_pkg::RAM_AW-1:0];
    case (st)
      BMM_IDLE: begin
        if (astb && hit_rom) begin
          next_ext = 1'b1;
          next_cnt = 8'(bmm_pkg::EXT_EXTRA_CYC);
          next_st  = BMM_ROM;
        end else if (astb && hit_ram) begin
          next_st  = BMM_RAM;
        end
      end
      BMM_RAM: begin
        if (!astb) begin
          next_st  = BMM_IDLE;                 // master abandoned
        end else if (ctl.rd) begin
          next_drv = '{data: ram[widx], oe: 1'b1};
          next_st  = BMM_DONE;
        end else if (ctl.wr && dstb) begin
          we       = 1'b1;
          next_st  = BMM_DONE;
        end
      end
      BMM_ROM: begin
        if (cnt > 8'h00) begin
          next_cnt = cnt - 8'h01;              // hold the cycle stretched
        end else begin
          next_ext = 1'b0;
          // writes to the routine store are dropped
          next_drv = '{data: rom[addr[bmm_pkg::ROM_AW-1:0]],
                       oe: ctl.rd};
          next_st  = BMM_DONE;
        end
        if (!astb) begin
          next_ext = 1'b0;
          next_drv = '{data: bmm_pkg::DATA_RST, oe: 1'b0};
          next_st  = BMM_IDLE;
        end
      end
      BMM_DONE: begin
        if (!astb && !dstb) begin
          next_drv = '{data: bmm_pkg::DATA_RST, oe: 1'b0};
          next_st  = BMM_IDLE;
        end
      end
      default: begin
        next_st  = BMM_IDLE;
        next_drv = '{data: bmm_pkg::DATA_RST, oe: 1'b0};
        next_ext = 1'b0;
      end
    endcase
  end

  // registers of the state machine
  always_ff @(posedge core_clk or negedge rst_l) begin
    if (!rst_l) begin
      st  <= BMM_IDLE;
      cnt <= 8'h00;
      drv <= '{data: bmm_pkg::DATA_RST, oe: 1'b0};
      ext <= 1'b0;
    end else if (clk_en) begin
      st  <= next_st;
      cnt <= next_cnt;
      drv <= next_drv;
      ext <= next_ext;
    end
  end

  // store write port, no reset on the array
  always_ff @(posedge core_clk) begin
    if (clk_en && we) begin
      ram[widx] <= wdata;
    end
  end

  assign data_out     = drv.data;
  assign data_oe      = drv.oe;
  assign ext_cycle    = ext;
  assign ext_cycle_oe = ext;

  ////////////////////////////////////////////////////////////////////////
  // checks

  // every check runs on the core clock and sleeps while reset is held
  default clocking bmm_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_l);

  a_ext_on_rom: assert property (
    clk_en && st == BMM_IDLE && astb && hit_rom |=> ext)
    else $error("extended line not raised for read-only access");
  a_ram_no_ext: assert property (
    st == BMM_RAM |-> !ext)
    else $error("read/write access stretched the cycle");
  a_no_drive_wr: assert property (
    data_oe |-> !ctl.wr || $past(ctl.rd))
    else $error("data lines driven on a write");
  a_oe_drops: assert property (
    clk_en && st == BMM_DONE && !astb && !dstb |=> !data_oe)
    else $error("data lines held after strobes fell");
  a_miss_idle: assert property (
    clk_en && st == BMM_IDLE && !hit_ram && !hit_rom |=> st == BMM_IDLE)
    else $error("answered a transaction outside the window");
  a_ram_write: assert property (
    clk_en && we |=> ram[$past(widx)] == $past(wdata))
    else $error("store word differs from the data written");
  a_rom_len: assert property (
    $rose(ext) && clk_en |-> ext [*2])
    else $error("extended line too short");
  a_base_held: assert property (
    base_ok |=> base_ok && $stable(base))
    else $error("window base changed after capture");

endmodule

// ---- bmm_master_model.sv ----
// Purpose: bus master model that drives the memory slave
// Assumes: requests change just after the falling clock edge
// Notes:   released data lines show a pattern changing every cycle
`timescale 1ns/100ps
module bmm_master_model (
  input  wire logic        core_clk,   // bus clock
  input  wire logic [15:0] data_out,   // slave drive value
  input  wire logic        data_oe,    // slave drive enable
  input  wire logic        ext_cycle,  // extended-cycle line
  output logic             addr_stb,   // address strobe
  output logic             data_stb,   // data strobe
  output logic             bus_mem,    // memory flag
  output logic             bus_rd,     // read flag
  output logic             bus_wr,     // write flag
  output logic      [15:0] bus_addr,   // address lines
  output logic      [15:0] data_in     // resolved data lines
);
  logic [15:0] wdata = 16'h0000;  // write data while driving
  logic        wdrv  = 1'b0;      // high while master drives data
  logic [15:0] last  = 16'h0000;  // wire level of the last cycle
  initial begin
    addr_stb = 1'b0;
    data_stb = 1'b0;
    bus_mem  = 1'b0;
    bus_rd   = 1'b0;
    bus_wr   = 1'b0;
    bus_addr = 16'h0000;
  end
  // wire level: slave on reads, master on writes, else changing
  always_comb begin
    if (data_oe === 1'b1) begin
      data_in = data_out;
    end else if (wdrv) begin
      data_in = wdata;
    end else begin
      data_in = ~last;
    end
  end
  // remember the wire so the idle pattern keeps changing
  always @(posedge core_clk) begin
    last <= data_in;
  end
  // one granted bus cycle; counts ext and data-drive cycles
  task automatic xfer(input logic m, r, w, input logic [15:0] a, d,
                      input int hold, output int ne, output int no,
                      output bit to);
    int i;
    ne = 0;
    no = 0;
    to = 1'b1;
    @(negedge core_clk);
    bus_addr = a;
    bus_mem = m;
    bus_rd = r;
    bus_wr = w;
    addr_stb = 1'b1;
    @(negedge core_clk);
    if (w) begin
      wdata = d;
      wdrv = 1'b1;
      data_stb = 1'b1;
    end
    for (i = 0; i < hold; i++) begin
      @(negedge core_clk);
      if (ext_cycle === 1'b1) ne++;
      if (data_oe === 1'b1) no++;
    end
    addr_stb = 1'b0;
    data_stb = 1'b0;
    wdrv = 1'b0;
    bus_addr = ~a;
    for (i = 0; i < 10 && to; i++) begin
      @(negedge core_clk);
      if (data_oe === 1'b0 && ext_cycle === 1'b0) to = 1'b0;
    end
    // keep the strobes low long enough for the slave's filter to see it
    repeat (4) @(negedge core_clk);
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_mem = 1'b0;
  endtask
endmodule

// ---- bus_memory_module_tb_top.sv ----
// Purpose: self-checking bench for the bus memory module
// Assumes: ROM fitted with all-zero contents, window strap 3
// Notes:   read results are compared by a separate monitor
`timescale 1ns/100ps
module bus_memory_module_tb_top;
  logic        core_clk = 1'b0;   // 40 MHz clock
  logic        rst_n    = 1'b0;   // reset, active low
  logic        clk_en   = 1'b1;   // run enable
  logic [3:0]  base_sel = 4'h3;   // strapped window
  logic        addr_stb, data_stb, bus_mem, bus_rd, bus_wr;
  logic [15:0] bus_addr, data_in, data_out;
  logic        data_oe, ext_cycle, oe_q, ext_oe, ext_q;
  logic [15:0] exp_q[$];          // expected read words
  logic [31:0] seed;              // xorshift state
  logic [31:0] r;
  logic [15:0] a, d;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          k;
  always #12.5 core_clk = ~core_clk;
  bmm_top #(.ROM_EN(1'b1)) bmm_top_i (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .base_sel(base_sel), .addr_stb(addr_stb), .data_stb(data_stb),
    .bus_mem(bus_mem), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .ext_cycle(ext_cycle), .ext_cycle_oe(ext_oe));
  bmm_master_model bmm_master_model_i (
    .core_clk(core_clk), .data_out(data_out), .data_oe(data_oe),
    .ext_cycle(ext_cycle), .addr_stb(addr_stb), .data_stb(data_stb),
    .bus_mem(bus_mem), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .data_in(data_in));
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic end_sim();
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one transfer; notes the read word, then checks drive and stretch
  task automatic op(input logic m, rd, wr, input logic [15:0] ad, dt,
                    input bit oe_exp, input int ext_exp);
    int  ne, no;
    bit  to;
    if (oe_exp) exp_q.push_back(dt);
    bmm_master_model_i.xfer(m, rd, wr, ad, dt, 40, ne, no, to);
    if (to) begin
      n_mismatch++;
      $display("[ERR] %0t slave did not release", $time);
      end_sim();
    end
    chk({15'h0000, no != 0}, {15'h0000, oe_exp});
    chk(ne[15:0], ext_exp[15:0]);
  endtask
  ////////////////////////////////////////////////////////////////////
  // monitor: compare the oldest note when the slave starts driving
  // sampled at the falling edge, where registered outputs have settled
  always @(negedge core_clk) begin
    oe_q <= data_oe;
    ext_q <= ext_cycle;
    if (data_oe === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) chk(16'hDEAD, 16'h0000);
      else chk(data_out, exp_q.pop_front());
    end
    // the extended line's enable follows the line as it rises and falls
    if (ext_cycle !== ext_q) begin
      chk({15'h0000, ext_oe}, {15'h0000, ext_cycle});
    end
  end
  initial begin
    #2500000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    seed = 32'd29107;
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge core_clk);
    // store words at window edges and random offsets, read back
    for (k = 0; k < 6; k++) begin
      r = rnd();
      a = {base_sel, (k == 0) ? 12'h000 : (k == 1) ? 12'hFFF : r[11:0]};
      d = r[31:16];
      op(1'b1, 1'b0, 1'b1, a, d, 1'b0, 0);
      op(1'b1, 1'b1, 1'b0, a, d, 1'b1, 0);
    end
    $display("test ram done");
    // other windows and peripheral cycles leave the store alone
    op(1'b1, 1'b1, 1'b0, {4'h4, a[11:0]}, d, 1'b0, 0);
    op(1'b0, 1'b1, 1'b0, a, d, 1'b0, 0);
    op(1'b0, 1'b0, 1'b1, a, ~d, 1'b0, 0);
    op(1'b1, 1'b0, 1'b1, {4'h5, a[11:0]}, ~d, 1'b0, 0);
    op(1'b1, 1'b1, 1'b0, a, d, 1'b1, 0);
    $display("test decode done");
    // read-only range: stretched cycle, writes have no effect
    for (k = 0; k < 2; k++) begin
      r = rnd();
      a = k ? 16'hFFFF : 16'hFF00;
      op(1'b1, 1'b1, 1'b0, a, 16'h0000, 1'b1, 29);
      op(1'b1, 1'b0, 1'b1, a, r[15:0], 1'b0, 29);
      op(1'b1, 1'b1, 1'b0, a, 16'h0000, 1'b1, 29);
    end
    $display("test rom done");
    repeat (4) @(negedge core_clk);
    chk(16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule
